// *** dv/pbp_pin_world.sv ***
// Behavioural model of the circuitry wired to the eight port pins.
// Assumes the bench drives ext_val/ext_oe after a rising edge of hclk.
`timescale 1ns/1ps
module pbp_pin_world (
    input  wire logic       hclk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_on,
    input  wire logic [7:0] ext_val,
    input  wire logic [7:0] ext_oe,
    output logic      [7:0] pin_in
);
    logic [7:0] last_lvl;

    // Undriven pins without pull-up wander: inverse of last level each cycle
    always_ff @(posedge hclk) begin
        last_lvl <= pin_in;
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i] === 1'b1) begin
                pin_in[i] = pin_out[i];
            end else if (ext_oe[i] === 1'b1) begin
                pin_in[i] = ext_val[i];
            end else if (pullup_on[i] === 1'b1) begin
                pin_in[i] = 1'b1;
            end else begin
                pin_in[i] = (last_lvl[i] === 1'b1) ? 1'b0 : 1'b1;
            end
        end
    end
endmodule // pbp_pin_world

// *** dv/port_pin_data_bidir_io_port_test.sv ***
// Self-checking bench for the eight-bit port block.
// Assumes the design under logic/ and the pin model pbp_pin_world.
`timescale 1ns/1ps
module port_pin_data_bidir_io_port_test;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic [7:0]  pin_in, pin_out, pin_oe, pullup_on, pin_level;
    logic [7:0]  ext_val = 8'h00;
    logic [7:0]  ext_oe = 8'hff;
    logic        ser_en = 1'b0, ck_out = 1'b0, ck_oe = 1'b0;
    logic        dt_out = 1'b0, dt_oe = 1'b0, tx_out = 1'b0;
    logic        lvp_mode, sync_mode, irq;
    logic [31:0] rd;
    int          err_count = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #10 hclk = ~hclk;

    pbp_port #(.PORT_WIDTH(8)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_on(pullup_on), .pin_level(pin_level),
        .serial_port_enable(ser_en), .sync_serial_clock_out(ck_out),
        .sync_serial_clock_oe(ck_oe), .sync_serial_data_out(dt_out),
        .sync_serial_data_oe(dt_oe), .async_tx_out(tx_out),
        .lvp_mode(lvp_mode), .sync_mode(sync_mode), .irq(irq)
    );

    pbp_pin_world world (
        .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_on(pullup_on),
        .ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in)
    );

    task automatic test_done();
        if (err_count == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles++;
        if (cycles >= 20000) begin
            err_count++;
            test_done();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // One single word transfer: address phase, then data phase
    task automatic xfer(input pbp_pkg::pbp_idx_t idx, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {20'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= pbp_pkg::HTRANS_NONSEQ;
        hsize  <= pbp_pkg::HSIZE_WORD;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input pbp_pkg::pbp_idx_t idx, input logic [7:0] d);
        xfer(idx, 1'b1, {24'h0, d});
        // Let the register update of this edge settle before outputs are compared
        #1;
    endtask

    task automatic rchk(input string name, input pbp_pkg::pbp_idx_t idx, input logic [7:0] e);
        xfer(idx, 1'b0, 32'h0);
        chk(name, {24'h0, e}, rd);
    endtask

    task automatic wait_irq(input logic lvl);
        for (int i = 0; i < 10 && irq !== lvl; i++) @(posedge hclk);
    endtask

    task automatic t_reset_values();
        rchk("opt_a", pbp_pkg::IDX_OPT_A, 8'hff);
        rchk("opt_b", pbp_pkg::IDX_OPT_B, 8'hff);
        rchk("dir_a", pbp_pkg::IDX_DIR_A, 8'hff);
        rchk("dir_b", pbp_pkg::IDX_DIR_B, 8'hff);
        chk("oe_rst", 8'h00, pin_oe);
        chk("pu_rst", 8'h00, pullup_on);
        rchk("unmapped", 10'h3ff, 8'h00);
    endtask

    task automatic t_drive_and_read();
        wr(pbp_pkg::IDX_PORT_B, 8'hca);
        wr(pbp_pkg::IDX_DIR_B, 8'hf0);
        rchk("dir_mirror", pbp_pkg::IDX_DIR_A, 8'hf0);
        chk("oe_dir", 8'h0f, pin_oe);
        chk("out_latch", 8'h0a, {4'h0, pin_out[3:0]});
        ext_val <= 8'h90;
        rchk("port_pins", pbp_pkg::IDX_PORT_A, 8'h9a);
        wr(pbp_pkg::IDX_PORT_A, 8'h65);
        rchk("port_mirror", pbp_pkg::IDX_PORT_B, 8'h95);
        chk("pin_level", 8'h95, pin_level);
        wr(pbp_pkg::IDX_OPT_B, 8'h7f);
        rchk("opt_mirror", pbp_pkg::IDX_OPT_A, 8'h7f);
        chk("pu_inputs", 8'hf0, pullup_on);
        wr(pbp_pkg::IDX_DIR_A, 8'h3c);
        chk("pu_outputs", 8'h3c, pullup_on);
        wr(pbp_pkg::IDX_CTRL, 8'h01);
        chk("lvp_mode", 32'h1, lvp_mode);
        chk("pu_lvp", 8'h2c, pullup_on);
        wr(pbp_pkg::IDX_CTRL, 8'h00);
        wr(pbp_pkg::IDX_OPT_A, 8'hff);
        chk("pu_off", 8'h00, pullup_on);
    endtask

    task automatic t_change();
        wr(pbp_pkg::IDX_DIR_A, 8'hf0);
        wr(pbp_pkg::IDX_IRQ_MASK, 8'h01);
        ext_val <= 8'h50;
        xfer(pbp_pkg::IDX_PORT_A, 1'b0, 32'h0);
        wr(pbp_pkg::IDX_IRQ_STAT, 8'h03);
        chk("irq_idle", 32'h0, irq);
        ext_val <= 8'h70;
        wait_irq(1'b1);
        chk("irq_change", 32'h1, irq);
        wr(pbp_pkg::IDX_IRQ_STAT, 8'h01);
        xfer(pbp_pkg::IDX_IRQ_STAT, 1'b0, 32'h0);
        chk("flag_held", 32'h1, rd & 32'h1);
        xfer(pbp_pkg::IDX_PORT_B, 1'b0, 32'h0);
        wr(pbp_pkg::IDX_IRQ_STAT, 8'h01);
        wait_irq(1'b0);
        chk("irq_cleared", 32'h0, irq);
        wr(pbp_pkg::IDX_IRQ_MASK, 8'h00);
        ext_val <= 8'h30;
        repeat (4) @(posedge hclk);
        chk("irq_masked", 32'h0, irq);
        wr(pbp_pkg::IDX_IRQ_MASK, 8'h01);
        chk("irq_unmask", 32'h1, irq);
        wr(pbp_pkg::IDX_PORT_A, 8'h00);
        wr(pbp_pkg::IDX_IRQ_STAT, 8'h01);
        wr(pbp_pkg::IDX_CTRL, 8'h01);
        ext_val <= 8'h20;
        repeat (4) @(posedge hclk);
        chk("lvp_nochg", 32'h0, irq);
        wr(pbp_pkg::IDX_CTRL, 8'h00);
    endtask

    task automatic t_serial();
        ser_en <= 1'b1;
        ck_out <= 1'b1;
        ck_oe  <= 1'b1;
        dt_oe  <= 1'b1;
        wr(pbp_pkg::IDX_CTRL, 8'h02);
        chk("sync_mode", 32'h1, sync_mode);
        chk("sync_oe", 2'h3, pin_oe[2:1]);
        chk("sync_out", 2'h2, pin_out[2:1]);
        dt_oe  <= 1'b0;
        tx_out <= 1'b1;
        wr(pbp_pkg::IDX_CTRL, 8'h00);
        chk("async_oe", 2'h2, pin_oe[2:1]);
        chk("async_tx", 32'h1, pin_out[2]);
        ser_en <= 1'b0;
    endtask

    task automatic t_warm_reset();
        wr(pbp_pkg::IDX_PORT_A, 8'h3c);
        wr(pbp_pkg::IDX_DIR_A, 8'h00);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        chk("oe_in_reset", 8'h00, pin_oe);
        hresetn <= 1'b1;
        rchk("dir_after", pbp_pkg::IDX_DIR_B, 8'hff);
        rchk("opt_after", pbp_pkg::IDX_OPT_B, 8'hff);
        wr(pbp_pkg::IDX_DIR_B, 8'h00);
        chk("latch_kept", 8'h3c, pin_out);
    endtask

    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset_values();
        t_drive_and_read();
        t_change();
        t_serial();
        t_warm_reset();
        test_done();
    end
endmodule // port_pin_data_bidir_io_port_test

// *** logic/pbp_chg_det.sv ***
// Change detector for the upper port pins.
// Assumes pins synchronous to hclk; refresh is a one-cycle pulse.
`timescale 1ns/1ps
module pbp_chg_det #(
    parameter int WIDTH = 4
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic [WIDTH-1:0] enable,
    input  wire logic             refresh,
    output logic                  mismatch
);
    if (WIDTH < 1) begin : g_chk
        $error("pbp_chg_det: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] old;
    } pbp_chg_s;

    pbp_chg_s st;
    pbp_chg_s next_st;

    always_comb begin
        next_st = st;
        if (refresh) begin
            next_st.old = pins;
        end
        mismatch = |((pins ^ st.old) & enable);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_refresh_then_change;
        refresh ##1 (!refresh && |((pins ^ $past(pins)) & enable));
    endsequence

    AST_CHG_MISMATCH: assert property (s_refresh_then_change |-> mismatch)
        else $error("Change after refresh did not raise mismatch");
endmodule // pbp_chg_det

// *** logic/pbp_pin_mux.sv ***
// Output latch, pin drivers, alternate functions and pull-up control.
// Assumes the pads resolve pin_out/pin_oe and apply pullup_on.
`timescale 1ns/1ps
module pbp_pin_mux #(
    parameter int W = 8
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         latch_we,
    input  wire logic [W-1:0] latch_din,
    input  wire logic [W-1:0] dir,
    input  wire logic         pullup_enable_n,
    input  wire logic         lvp_mode,
    input  wire logic         serial_port_enable,
    input  wire logic         sync_mode,
    input  wire logic         sync_serial_clock_out,
    input  wire logic         sync_serial_clock_oe,
    input  wire logic         sync_serial_data_out,
    input  wire logic         sync_serial_data_oe,
    input  wire logic         async_tx_out,
    output logic [W-1:0]      pin_out,
    output logic [W-1:0]      pin_oe,
    output logic [W-1:0]      pullup_on
);
    if (W != 8) begin : g_chk
        $error("pbp_pin_mux: only an 8-bit port is supported");
    end

    typedef struct packed {
        logic [W-1:0] latch;
    } pbp_mux_s;

    pbp_mux_s st;
    pbp_mux_s next_st;

    always_comb begin
        next_st = st;
        if (latch_we) begin
            next_st.latch = latch_din;
        end
        pin_out = st.latch;
        pin_oe  = ~dir;
        if (serial_port_enable) begin
            if (sync_mode) begin
                pin_out[pbp_pkg::PIN_SER_CLOCK] = sync_serial_clock_out;
                pin_oe[pbp_pkg::PIN_SER_CLOCK]  = sync_serial_clock_oe;
                pin_out[pbp_pkg::PIN_SER_DATA]  = sync_serial_data_out;
                pin_oe[pbp_pkg::PIN_SER_DATA]   = sync_serial_data_oe;
            end else begin
                pin_out[pbp_pkg::PIN_SER_CLOCK] = async_tx_out;
                pin_oe[pbp_pkg::PIN_SER_CLOCK]  = 1'b1;
                pin_oe[pbp_pkg::PIN_SER_DATA]   = 1'b0;
            end
        end
        if (lvp_mode) begin
            pin_oe[pbp_pkg::PIN_PROG] = 1'b0;
        end
        pullup_on = ~pin_oe & dir & {W{!pullup_enable_n}};
        if (lvp_mode) begin
            pullup_on[pbp_pkg::PIN_PROG] = 1'b0;
        end
    end

    // Latch has no reset: unknown at power-up, kept over resets
    always_ff @(posedge hclk) begin
        st <= next_st;
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_DIR_DRIVE: assert property (!serial_port_enable && !lvp_mode |-> pin_oe == ~dir)
        else $error("Pin drive does not follow direction");
    AST_PULLUP_OUT: assert property ((pullup_on & (~dir | pin_oe)) == '0)
        else $error("Pull-up on while pin is an output");
    AST_PULLUP_ON: assert property (!pullup_enable_n && !lvp_mode && !serial_port_enable
        |-> pullup_on == dir)
        else $error("Common pull-up enable not applied to inputs");
    AST_LVP_PIN: assert property (lvp_mode
        |-> !pullup_on[pbp_pkg::PIN_PROG] && !pin_oe[pbp_pkg::PIN_PROG])
        else $error("Programming pin driven or pulled up");
    AST_SYNC_CLK: assert property (serial_port_enable && sync_mode
        |-> pin_oe[pbp_pkg::PIN_SER_CLOCK] == sync_serial_clock_oe
            && pin_oe[pbp_pkg::PIN_SER_DATA] == sync_serial_data_oe)
        else $error("Synchronous serial pins not routed");
endmodule // pbp_pin_mux

// *** logic/pbp_pkg.sv ***
// Constants, register indices and helpers for the port block.
// Assumes a 32-bit AHB-Lite slave; register byte address = 4 * index.
package pbp_pkg;
    typedef logic [9:0] pbp_idx_t;

    localparam pbp_idx_t IDX_PORT_A   = 10'h006;
    localparam pbp_idx_t IDX_PORT_B   = 10'h106;
    localparam pbp_idx_t IDX_OPT_A    = 10'h081;
    localparam pbp_idx_t IDX_OPT_B    = 10'h181;
    localparam pbp_idx_t IDX_DIR_A    = 10'h086;
    localparam pbp_idx_t IDX_DIR_B    = 10'h186;
    localparam pbp_idx_t IDX_IRQ_STAT = 10'h200;
    localparam pbp_idx_t IDX_IRQ_MASK = 10'h201;
    localparam pbp_idx_t IDX_CTRL     = 10'h202;

    localparam int ADDR_LSB = 2;
    localparam int ADDR_MSB = 11;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

    localparam logic [7:0] DIR_RESET  = 8'hff;
    localparam logic [7:0] OPT_RESET  = 8'hff;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [1:0] IRQ_RESET  = 2'h0;

    localparam int OPT_PULLUP_EN_N = 7;
    localparam int OPT_EXT_EDGE    = 6;
    localparam int CTRL_W          = 2;
    localparam int CTRL_LVP        = 0;
    localparam int CTRL_SYNC       = 1;
    localparam int IRQ_W           = 2;
    localparam int IRQ_CHANGE      = 0;
    localparam int IRQ_EXT         = 1;

    localparam int PIN_EXT_IRQ   = 0;
    localparam int PIN_SER_DATA  = 1;
    localparam int PIN_SER_CLOCK = 2;
    localparam int PIN_PROG      = 4;
    localparam int CHG_LSB       = 4;
    localparam int CHG_W         = 4;

    typedef enum logic [2:0] {
        PBP_BUS_IDLE  = 3'h1,
        PBP_BUS_WRITE = 3'h2,
        PBP_BUS_READ  = 3'h4
    } pbp_bus_e;

    // Mirrored register decode
    function automatic logic pbp_hit(pbp_idx_t idx, pbp_idx_t a, pbp_idx_t b);
        return (idx == a) || (idx == b);
    endfunction
endpackage

// *** logic/pbp_port.sv ***
// Eight-bit bidirectional port with AHB-Lite register access.
// Assumes pins synchronous to hclk and a single zero-wait AHB-Lite master.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps
module pbp_port #(
    parameter int PORT_WIDTH = 8
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [PORT_WIDTH-1:0] pin_in,
    output logic      [PORT_WIDTH-1:0] pin_out,
    output logic      [PORT_WIDTH-1:0] pin_oe,
    output logic      [PORT_WIDTH-1:0] pullup_on,
    output logic      [PORT_WIDTH-1:0] pin_level,
    input  wire logic                  serial_port_enable,
    input  wire logic                  sync_serial_clock_out,
    input  wire logic                  sync_serial_clock_oe,
    input  wire logic                  sync_serial_data_out,
    input  wire logic                  sync_serial_data_oe,
    input  wire logic                  async_tx_out,
    output logic                       lvp_mode,
    output logic                       sync_mode,
    output logic                       irq
);
    localparam int W = PORT_WIDTH;
    localparam int IW = pbp_pkg::IRQ_W;
    localparam int PROG_BIT = pbp_pkg::PIN_PROG - pbp_pkg::CHG_LSB;

    if (W != 8) begin : g_chk
        $error("pbp_port: only an 8-bit port is supported");
    end

    typedef struct packed {
        pbp_pkg::pbp_bus_e          bus;
        pbp_pkg::pbp_idx_t          idx;
        logic [W-1:0]               dir;
        logic [W-1:0]               option;
        logic [pbp_pkg::CTRL_W-1:0] ctrl;
        logic [IW-1:0]              irq_stat;
        logic [IW-1:0]              irq_mask;
        logic [31:0]                rdata;
        logic [W-1:0]               level;
    } pbp_state_s;

    localparam pbp_state_s RESET_ST = '{
        bus:      pbp_pkg::PBP_BUS_IDLE,
        idx:      '0,
        dir:      pbp_pkg::DIR_RESET,
        option:   pbp_pkg::OPT_RESET,
        ctrl:     pbp_pkg::CTRL_RESET,
        irq_stat: pbp_pkg::IRQ_RESET,
        irq_mask: pbp_pkg::IRQ_RESET,
        rdata:    '0,
        level:    '0
    };

    pbp_state_s                 st;
    pbp_state_s                 next_st;
    pbp_pkg::pbp_idx_t          a_idx;
    logic                       accept;
    logic                       latch_we;
    logic                       refresh;
    logic                       mismatch;
    logic                       ext_event;
    logic [IW-1:0]              stat_set;
    logic [IW-1:0]              stat_clr;
    logic [W-1:0]               rd_val;
    logic [pbp_pkg::CHG_W-1:0]  chg_en;

    assign a_idx = haddr[pbp_pkg::ADDR_MSB:pbp_pkg::ADDR_LSB];

    always_comb begin
        next_st       = st;
        next_st.bus   = pbp_pkg::PBP_BUS_IDLE;
        next_st.level = pin_in;
        accept        = hsel && hready && (htrans == pbp_pkg::HTRANS_NONSEQ)
                        && (hsize == pbp_pkg::HSIZE_WORD);
        latch_we      = 1'b0;
        stat_clr      = '0;
        rd_val        = '0;

        // Data phase of a write
        if (st.bus == pbp_pkg::PBP_BUS_WRITE) begin
            if (pbp_pkg::pbp_hit(st.idx, pbp_pkg::IDX_PORT_A, pbp_pkg::IDX_PORT_B)) begin
                latch_we = 1'b1;
            end else if (pbp_pkg::pbp_hit(st.idx, pbp_pkg::IDX_DIR_A,
                                          pbp_pkg::IDX_DIR_B)) begin
                next_st.dir = hwdata[W-1:0];
            end else if (pbp_pkg::pbp_hit(st.idx, pbp_pkg::IDX_OPT_A,
                                          pbp_pkg::IDX_OPT_B)) begin
                next_st.option = hwdata[W-1:0];
            end else if (st.idx == pbp_pkg::IDX_CTRL) begin
                next_st.ctrl = hwdata[pbp_pkg::CTRL_W-1:0];
            end else if (st.idx == pbp_pkg::IDX_IRQ_MASK) begin
                next_st.irq_mask = hwdata[IW-1:0];
            end else if (st.idx == pbp_pkg::IDX_IRQ_STAT) begin
                stat_clr = hwdata[IW-1:0];
            end
        end

        // Edge on the external interrupt pin, polarity from the option register
        if (st.option[pbp_pkg::OPT_EXT_EDGE]) begin
            ext_event = pin_in[pbp_pkg::PIN_EXT_IRQ] && !st.level[pbp_pkg::PIN_EXT_IRQ];
        end else begin
            ext_event = !pin_in[pbp_pkg::PIN_EXT_IRQ] && st.level[pbp_pkg::PIN_EXT_IRQ];
        end

        // Sticky flags, a set wins over a write-one clear
        stat_set                      = '0;
        stat_set[pbp_pkg::IRQ_CHANGE] = mismatch;
        stat_set[pbp_pkg::IRQ_EXT]    = ext_event;
        next_st.irq_stat              = (st.irq_stat & ~stat_clr) | stat_set;

        // Address phase
        if (accept) begin
            next_st.idx = a_idx;
            if (hwrite) begin
                next_st.bus = pbp_pkg::PBP_BUS_WRITE;
            end else begin
                next_st.bus = pbp_pkg::PBP_BUS_READ;
                if (pbp_pkg::pbp_hit(a_idx, pbp_pkg::IDX_PORT_A, pbp_pkg::IDX_PORT_B)) begin
                    rd_val = pin_in;
                end else if (pbp_pkg::pbp_hit(a_idx, pbp_pkg::IDX_DIR_A,
                                              pbp_pkg::IDX_DIR_B)) begin
                    rd_val = next_st.dir;
                end else if (pbp_pkg::pbp_hit(a_idx, pbp_pkg::IDX_OPT_A,
                                              pbp_pkg::IDX_OPT_B)) begin
                    rd_val = next_st.option;
                end else if (a_idx == pbp_pkg::IDX_CTRL) begin
                    rd_val = W'(next_st.ctrl);
                end else if (a_idx == pbp_pkg::IDX_IRQ_MASK) begin
                    rd_val = W'(next_st.irq_mask);
                end else if (a_idx == pbp_pkg::IDX_IRQ_STAT) begin
                    rd_val = W'(next_st.irq_stat);
                end
                next_st.rdata = 32'(rd_val);
            end
        end

        // Any port read or write ends the mismatch
        refresh = latch_we || (accept && !hwrite
                  && pbp_pkg::pbp_hit(a_idx, pbp_pkg::IDX_PORT_A, pbp_pkg::IDX_PORT_B));

        // Change detection only on input pins, and not on the programming pin in LVP mode
        chg_en = st.dir[pbp_pkg::CHG_LSB +: pbp_pkg::CHG_W];
        if (st.ctrl[pbp_pkg::CTRL_LVP]) begin
            chg_en[PROG_BIT] = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= RESET_ST;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata    = st.rdata;
    assign hreadyout = 1'b1;
    assign hresp     = pbp_pkg::HRESP_OKAY;
    assign pin_level = st.level;
    assign lvp_mode  = st.ctrl[pbp_pkg::CTRL_LVP];
    assign sync_mode = st.ctrl[pbp_pkg::CTRL_SYNC];
    assign irq       = |(st.irq_stat & st.irq_mask);

    pbp_chg_det #(
        .WIDTH (pbp_pkg::CHG_W)
    ) u_chg_det (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pins     (pin_in[pbp_pkg::CHG_LSB +: pbp_pkg::CHG_W]),
        .enable   (chg_en),
        .refresh  (refresh),
        .mismatch (mismatch)
    );

    pbp_pin_mux #(
        .W (W)
    ) u_pin_mux (
        .hclk                  (hclk),
        .hresetn               (hresetn),
        .latch_we              (latch_we),
        .latch_din             (hwdata[W-1:0]),
        .dir                   (st.dir),
        .pullup_enable_n       (st.option[pbp_pkg::OPT_PULLUP_EN_N]),
        .lvp_mode              (lvp_mode),
        .serial_port_enable    (serial_port_enable),
        .sync_mode             (sync_mode),
        .sync_serial_clock_out (sync_serial_clock_out),
        .sync_serial_clock_oe  (sync_serial_clock_oe),
        .sync_serial_data_out  (sync_serial_data_out),
        .sync_serial_data_oe   (sync_serial_data_oe),
        .async_tx_out          (async_tx_out),
        .pin_out               (pin_out),
        .pin_oe                (pin_oe),
        .pullup_on             (pullup_on)
    );

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_port_read;
        accept && !hwrite
            && pbp_pkg::pbp_hit(a_idx, pbp_pkg::IDX_PORT_A, pbp_pkg::IDX_PORT_B);
    endsequence

    sequence s_dir_write_b;
        (accept && hwrite && a_idx == pbp_pkg::IDX_DIR_B) ##1 1'b1;
    endsequence

    sequence s_opt_write_a;
        (accept && hwrite && a_idx == pbp_pkg::IDX_OPT_A) ##1 1'b1;
    endsequence

    AST_DIR_RESET: assert property ($rose(hresetn) |-> st.dir == pbp_pkg::DIR_RESET)
        else $error("Direction register not all ones after reset");
    AST_OPT_RESET: assert property ($rose(hresetn)
        |-> st.option == pbp_pkg::OPT_RESET && pullup_on == '0)
        else $error("Option register or pull-ups wrong after reset");
    AST_PORT_READ: assert property (s_port_read
        |=> st.rdata == 32'($past(pin_in)))
        else $error("Port read did not return pin levels");
    AST_PORT_WRITE_ONLY: assert property ((st.bus == pbp_pkg::PBP_BUS_WRITE
        && pbp_pkg::pbp_hit(st.idx, pbp_pkg::IDX_PORT_A, pbp_pkg::IDX_PORT_B))
        |=> $stable(st.dir) && $stable(st.option))
        else $error("Port write disturbed other registers");
    AST_CHANGE_FLAG: assert property (mismatch |=> st.irq_stat[pbp_pkg::IRQ_CHANGE])
        else $error("Mismatch did not set change flag");
    AST_DIR_MIRROR: assert property (s_dir_write_b
        |=> st.dir == $past(hwdata[W-1:0]))
        else $error("Direction write via mirror address lost");
    AST_OPT_MIRROR: assert property (s_opt_write_a
        |=> st.option == $past(hwdata[W-1:0]))
        else $error("Option write via first address lost");
    AST_LVP_NO_CHG: assert property (lvp_mode && st.dir == '1
        && (pin_in ^ $past(pin_in)) == (W'(1) << pbp_pkg::PIN_PROG)
        && !$past(mismatch) |-> !mismatch)
        else $error("Programming pin raised change detection");
endmodule // pbp_port
